//--- hdl/axis_pkg.sv
// Constants shared by the axis status and supervision logic
package axis_pkg;
   // Parameter numbers of the axis registers
   localparam logic [7:0] IDX_FAULT_STATUS   = 8'hd0;
   localparam logic [7:0] IDX_ENC_COUNT      = 8'hd1;
   localparam logic [7:0] IDX_ENC_DIVIDER    = 8'hd2;
   localparam logic [7:0] IDX_ENC_DEV_LIMIT  = 8'hd4;
   localparam logic [7:0] IDX_STANDBY_DELAY  = 8'hd6;
   localparam logic [7:0] IDX_RESOLVER_ANGLE = 8'hd7;
   localparam logic [7:0] IDX_EXT_COUNT      = 8'hd8;
   localparam logic [7:0] IDX_EXT_DIVIDER    = 8'hd9;
   localparam logic [7:0] IDX_EXT_DEV_LIMIT  = 8'hda;

   // Fault status bit positions
   localparam int STAT_STALL   = 0;
   localparam int STAT_OT      = 1;
   localparam int STAT_OTPW    = 2;
   localparam int STAT_S2G_A   = 3;
   localparam int STAT_S2G_B   = 4;
   localparam int STAT_OPEN_A  = 5;
   localparam int STAT_OPEN_B  = 6;
   localparam int STAT_STILL   = 7;
   localparam int STAT_W       = 8;

   // Positions of the step, encoder and resolver pins in the synchroniser word
   localparam int PIN_STEP     = 7;
   localparam int PIN_ENC_A    = 8;
   localparam int PIN_ENC_B    = 9;
   localparam int PIN_EXT_A    = 10;
   localparam int PIN_EXT_B    = 11;
   localparam int PIN_ANGLE    = 12;

   localparam int DATA_W       = 32;
   localparam int ANGLE_W      = 10;
   localparam int DELAY_W      = 16;

   // Reset values
   localparam logic [15:0] STANDBY_DELAY_RST = 16'h00c8;
   localparam logic [31:0] DEV_LIMIT_RST     = 32'h0000_0000;
   localparam logic [31:0] DIVIDER_RST       = 32'h0000_0000;

   // Timing
   localparam int CLK_PERIOD_NS  = 10;
   localparam int STILL_EXP      = 20;
   localparam int STILL_CYC      = 1 << STILL_EXP;
   localparam int DELAY_UNIT_MS  = 10;
   localparam int DELAY_UNIT_CYC = (DELAY_UNIT_MS * 1000000) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_RUN     = 2'b01,
      ST_STANDBY = 2'b10
   } power_state_t;
endpackage

//--- hdl/axis_supervisor.sv
// Axis driver status, encoder supervision and standstill power control
`timescale 1ns/1ps
`default_nettype none
module axis_supervisor #(
   parameter int STILL_CYCLES = axis_pkg::STILL_CYC,
   parameter int UNIT_CYCLES  = axis_pkg::DELAY_UNIT_CYC
) (
   input  wire logic                           clk_i,
   input  wire logic                           sys_rst_i,
   // Numbered axis parameter access
   input  wire logic                           par_wr_i,
   input  wire logic                           par_rd_i,
   input  wire logic [7:0]                     par_num_i,
   input  wire logic [axis_pkg::DATA_W-1:0]    par_wdata_i,
   output logic      [axis_pkg::DATA_W-1:0]    par_rdata_o,
   output logic                                par_rvalid_o,
   // Driver status pins
   input  wire logic                           stall_i,
   input  wire logic                           ot_i,
   input  wire logic                           otpw_i,
   input  wire logic                           s2g_a_i,
   input  wire logic                           s2g_b_i,
   input  wire logic                           open_a_i,
   input  wire logic                           open_b_i,
   input  wire logic                           step_i,
   // Encoder and resolver pins
   input  wire logic                           enc_a_i,
   input  wire logic                           enc_b_i,
   input  wire logic                           ext_a_i,
   input  wire logic                           ext_b_i,
   input  wire logic [axis_pkg::ANGLE_W-1:0]   resolver_i,
   // Commanded position from the motion logic, same clock
   input  wire logic [axis_pkg::DATA_W-1:0]    act_pos_i,
   output logic                                motor_stop_o,
   output logic                                standby_o,
   output logic      [axis_pkg::DATA_W-1:0]    enc_divider_o,
   output logic      [axis_pkg::DATA_W-1:0]    ext_divider_o
);
   localparam int PIN_W = axis_pkg::PIN_ANGLE + axis_pkg::ANGLE_W;
   localparam int CNT_W = $clog2(STILL_CYCLES + 1);
   localparam int UNIT_W = $clog2(UNIT_CYCLES + 1);

   logic [PIN_W-1:0] pins_raw;
   logic [PIN_W-1:0] meta_q;
   logic [PIN_W-1:0] sync_q;
   logic [axis_pkg::STAT_W-1:0] stat_q;
   logic [axis_pkg::DATA_W-1:0] enc_count;
   logic [axis_pkg::DATA_W-1:0] ext_count;
   logic [axis_pkg::DATA_W-1:0] enc_lim_q;
   logic [axis_pkg::DATA_W-1:0] ext_lim_q;
   logic [axis_pkg::DELAY_W-1:0] delay_q;
   logic [CNT_W-1:0] still_cnt_q;
   logic [UNIT_W-1:0] unit_cnt_q;
   logic [axis_pkg::DELAY_W-1:0] units_q;
   logic step_p_q;
   logic step_edge;
   logic dev_int;
   logic dev_ext;
   logic wr_enc;
   logic wr_ext;
   axis_pkg::power_state_t pstate_q;

   // Each pin gets two flops; resolver bits may skew, so its source must hold a word steady
   assign pins_raw = {resolver_i, ext_b_i, ext_a_i, enc_b_i, enc_a_i, step_i,
                      open_b_i, open_a_i, s2g_b_i, s2g_a_i, otpw_i, ot_i, stall_i};

   generate
      for (genvar i = 0; i < PIN_W; i++)
      begin : g_sync
         always_ff @(posedge clk_i or posedge sys_rst_i)
         begin
            if (sys_rst_i)
            begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end
            else
            begin
               meta_q[i] <= pins_raw[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate

   function automatic logic exceeds(input logic [31:0] pos, input logic [31:0] enc,
                                    input logic [31:0] lim);
      logic signed [32:0] diff;
      logic [32:0] mag;
      diff = $signed({pos[31], pos}) - $signed({enc[31], enc});
      mag = diff[32] ? 33'(-diff) : 33'(diff);
      exceeds = (lim != 32'h0000_0000) && (mag > {1'b0, lim});
   endfunction

   assign step_edge = sync_q[axis_pkg::PIN_STEP] & ~step_p_q;
   assign wr_enc = par_wr_i && (par_num_i == axis_pkg::IDX_ENC_COUNT);
   assign wr_ext = par_wr_i && (par_num_i == axis_pkg::IDX_EXT_COUNT);

   quad_counter #(.W(axis_pkg::DATA_W)) u_enc (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .a_i        (sync_q[axis_pkg::PIN_ENC_A]),
      .b_i        (sync_q[axis_pkg::PIN_ENC_B]),
      .load_i     (wr_enc),
      .load_val_i (par_wdata_i),
      .count_o    (enc_count)
   );

   quad_counter #(.W(axis_pkg::DATA_W)) u_ext (
      .clk_i      (clk_i),
      .sys_rst_i  (sys_rst_i),
      .a_i        (sync_q[axis_pkg::PIN_EXT_A]),
      .b_i        (sync_q[axis_pkg::PIN_EXT_B]),
      .load_i     (wr_ext),
      .load_val_i (par_wdata_i),
      .count_o    (ext_count)
   );

   // Host-written settings
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         enc_lim_q     <= axis_pkg::DEV_LIMIT_RST;
         ext_lim_q     <= axis_pkg::DEV_LIMIT_RST;
         delay_q       <= axis_pkg::STANDBY_DELAY_RST;
         enc_divider_o <= axis_pkg::DIVIDER_RST;
         ext_divider_o <= axis_pkg::DIVIDER_RST;
      end
      else if (par_wr_i)
      begin
         case (par_num_i)
            axis_pkg::IDX_ENC_DEV_LIMIT: enc_lim_q <= {1'b0, par_wdata_i[30:0]};
            axis_pkg::IDX_EXT_DEV_LIMIT: ext_lim_q <= par_wdata_i;
            axis_pkg::IDX_STANDBY_DELAY: delay_q <= par_wdata_i[axis_pkg::DELAY_W-1:0];
            axis_pkg::IDX_ENC_DIVIDER: enc_divider_o <= par_wdata_i;
            axis_pkg::IDX_EXT_DIVIDER: ext_divider_o <= par_wdata_i;
            default: ;
         endcase
      end
   end

   // Standstill window counter saturates so the flag holds while idle
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         step_p_q    <= 1'b0;
         still_cnt_q <= '0;
      end
      else
      begin
         step_p_q <= sync_q[axis_pkg::PIN_STEP];
         if (step_edge)
            still_cnt_q <= '0;
         else if (still_cnt_q != CNT_W'(STILL_CYCLES))
            still_cnt_q <= still_cnt_q + CNT_W'(1);
      end
   end

   // Status byte follows the synchronised driver flags
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         stat_q <= '0;
      else
      begin
         stat_q[axis_pkg::STAT_STALL]  <= sync_q[axis_pkg::STAT_STALL];
         stat_q[axis_pkg::STAT_OT]     <= sync_q[axis_pkg::STAT_OT];
         stat_q[axis_pkg::STAT_OTPW]   <= sync_q[axis_pkg::STAT_OTPW];
         stat_q[axis_pkg::STAT_S2G_A]  <= sync_q[axis_pkg::STAT_S2G_A];
         stat_q[axis_pkg::STAT_S2G_B]  <= sync_q[axis_pkg::STAT_S2G_B];
         stat_q[axis_pkg::STAT_OPEN_A] <= sync_q[axis_pkg::STAT_OPEN_A];
         stat_q[axis_pkg::STAT_OPEN_B] <= sync_q[axis_pkg::STAT_OPEN_B];
         stat_q[axis_pkg::STAT_STILL]  <= (still_cnt_q == CNT_W'(STILL_CYCLES)) && !step_edge;
      end
   end

   // Deviation checks; a zero limit inside exceeds() turns each one off
   assign dev_int = exceeds(act_pos_i, enc_count, enc_lim_q);
   assign dev_ext = exceeds(act_pos_i, ext_count, ext_lim_q);

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         motor_stop_o <= 1'b0;
      else
         motor_stop_o <= dev_int | dev_ext;
   end

   // Standstill timer in delay units; any step returns to run current
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         unit_cnt_q <= '0;
         units_q    <= '0;
         pstate_q   <= axis_pkg::ST_RUN;
      end
      else if (step_edge)
      begin
         unit_cnt_q <= '0;
         units_q    <= '0;
         pstate_q   <= axis_pkg::ST_RUN;
      end
      else
      begin
         case (pstate_q)
            axis_pkg::ST_RUN:
            begin
               if (unit_cnt_q == UNIT_W'(UNIT_CYCLES - 1))
               begin
                  unit_cnt_q <= '0;
                  units_q    <= units_q + 16'h0001;
               end
               else
                  unit_cnt_q <= unit_cnt_q + UNIT_W'(1);
               // A zero delay acts as one unit so standby never comes instantly
               if (units_q >= delay_q && units_q != 16'h0000)
                  pstate_q <= axis_pkg::ST_STANDBY;
            end
            axis_pkg::ST_STANDBY: pstate_q <= axis_pkg::ST_STANDBY;
            default: pstate_q <= axis_pkg::ST_RUN;
         endcase
      end
   end

   assign standby_o = (pstate_q == axis_pkg::ST_STANDBY);

   // Read port answers one cycle after the request; unknown numbers read zero
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         par_rdata_o  <= '0;
         par_rvalid_o <= 1'b0;
      end
      else
      begin
         par_rvalid_o <= par_rd_i;
         if (par_rd_i)
         begin
            case (par_num_i)
               axis_pkg::IDX_FAULT_STATUS:   par_rdata_o <= {24'h00_0000, stat_q};
               axis_pkg::IDX_ENC_COUNT:      par_rdata_o <= enc_count;
               axis_pkg::IDX_ENC_DIVIDER:    par_rdata_o <= enc_divider_o;
               axis_pkg::IDX_ENC_DEV_LIMIT:  par_rdata_o <= enc_lim_q;
               axis_pkg::IDX_STANDBY_DELAY:  par_rdata_o <= {16'h0000, delay_q};
               axis_pkg::IDX_RESOLVER_ANGLE: par_rdata_o <= {22'h00_0000, sync_q[PIN_W-1:axis_pkg::PIN_ANGLE]};
               axis_pkg::IDX_EXT_COUNT:      par_rdata_o <= ext_count;
               axis_pkg::IDX_EXT_DIVIDER:    par_rdata_o <= ext_divider_o;
               axis_pkg::IDX_EXT_DEV_LIMIT:  par_rdata_o <= ext_lim_q;
               default:                      par_rdata_o <= '0;
            endcase
         end
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   property p_stall;
      $rose(sync_q[axis_pkg::STAT_STALL]) |=> stat_q[axis_pkg::STAT_STALL];
   endproperty
   a_stall: assert property (p_stall) else $error("stall bit not set");

   property p_temp;
      ##1 (stat_q[2:1] == $past(sync_q[2:1]));
   endproperty
   a_temp: assert property (p_temp) else $error("temperature bits wrong");

   property p_prewarn;
      sync_q[2] && !sync_q[1] |=> stat_q[axis_pkg::STAT_OTPW] && !stat_q[axis_pkg::STAT_OT];
   endproperty
   a_prewarn: assert property (p_prewarn) else $error("prewarn bit wrong");

   property p_coil;
      ##1 ({stat_q[6:3]} == $past(sync_q[6:3]));
   endproperty
   a_coil: assert property (p_coil) else $error("coil fault bits wrong");

   sequence s_step;
      step_edge;
   endsequence
   sequence s_quiet;
      !stat_q[axis_pkg::STAT_STILL] [*2];
   endsequence
   property p_still_clear;
      s_step |=> s_quiet;
   endproperty
   a_still_clear: assert property (p_still_clear) else $error("still set after step");

   property p_still_set;
      stat_q[axis_pkg::STAT_STILL] |-> still_cnt_q == CNT_W'(STILL_CYCLES);
   endproperty
   a_still_set: assert property (p_still_set) else $error("still set too early");

   property p_dev_stop;
      (dev_int || dev_ext) |=> motor_stop_o;
   endproperty
   a_dev_stop: assert property (p_dev_stop) else $error("deviation did not stop");

   property p_dev_off;
      (enc_lim_q == 32'h0000_0000 && ext_lim_q == 32'h0000_0000) |=> !motor_stop_o;
   endproperty
   a_dev_off: assert property (p_dev_off) else $error("stop with checks off");

   property p_standby_exit;
      step_edge |=> !standby_o;
   endproperty
   a_standby_exit: assert property (p_standby_exit) else $error("standby after step");

   property p_angle;
      par_rd_i && par_num_i == axis_pkg::IDX_RESOLVER_ANGLE |=>
         par_rvalid_o && par_rdata_o == {22'h00_0000, $past(sync_q[PIN_W-1:axis_pkg::PIN_ANGLE])};
   endproperty
   a_angle: assert property (p_angle) else $error("angle read wrong");

   property p_load;
      wr_enc |=> enc_count == $past(par_wdata_i);
   endproperty
   a_load: assert property (p_load) else $error("encoder load lost");
endmodule
`default_nettype wire

//--- hdl/quad_counter.sv
// Signed quadrature position counter with host load
`timescale 1ns/1ps
`default_nettype none
module quad_counter #(
   parameter int W = 32
) (
   input  wire logic         clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic         a_i,
   input  wire logic         b_i,
   input  wire logic         load_i,
   input  wire logic [W-1:0] load_val_i,
   output logic      [W-1:0] count_o
);
   logic a_p_q;
   logic b_p_q;
   logic step;
   logic up;

   // A single-channel change is a step; both at once is a glitch and is dropped
   assign step = (a_i ^ a_p_q) ^ (b_i ^ b_p_q);
   assign up   = a_i ^ b_p_q;

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         a_p_q <= 1'b0;
         b_p_q <= 1'b0;
      end
      else
      begin
         a_p_q <= a_i;
         b_p_q <= b_i;
      end
   end

   // Load wins over a step in the same cycle, counting resumes from it
   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         count_o <= '0;
      else if (load_i)
         count_o <= load_val_i;
      else if (step)
         count_o <= up ? count_o + W'(1) : count_o - W'(1);
   end
endmodule
`default_nettype wire

//--- test/axis_supervisor_bench.sv
// Self-checking bench for the axis status and supervision block
`timescale 1ns/1ps
`default_nettype none
module axis_supervisor_bench;
   logic        clk_i = 1'b0;
   logic        sys_rst_i = 1'b1;
   logic        par_wr, par_rd;
   logic [7:0]  par_num;
   logic [31:0] par_wdata, par_rdata, act_pos;
   logic        par_rvalid, motor_stop, standby;
   logic [31:0] enc_div, ext_div;
   logic [6:0]  flags;
   logic        step, enc_a, enc_b, ext_a, ext_b;
   logic [9:0]  angle;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          cycles = 0;

   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   // Short counts keep the standstill and standby waits to a few cycles
   axis_supervisor #(.STILL_CYCLES(16), .UNIT_CYCLES(4)) i_axis_supervisor (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .par_wr_i(par_wr), .par_rd_i(par_rd),
      .par_num_i(par_num), .par_wdata_i(par_wdata), .par_rdata_o(par_rdata),
      .par_rvalid_o(par_rvalid), .stall_i(flags[0]), .ot_i(flags[1]), .otpw_i(flags[2]),
      .s2g_a_i(flags[3]), .s2g_b_i(flags[4]), .open_a_i(flags[5]), .open_b_i(flags[6]),
      .step_i(step), .enc_a_i(enc_a), .enc_b_i(enc_b), .ext_a_i(ext_a), .ext_b_i(ext_b),
      .resolver_i(angle), .act_pos_i(act_pos), .motor_stop_o(motor_stop),
      .standby_o(standby), .enc_divider_o(enc_div), .ext_divider_o(ext_div));

   driver_model i_driver_model (
      .clk_i(clk_i), .flags_o(flags), .step_o(step), .enc_a_o(enc_a), .enc_b_o(enc_b),
      .ext_a_o(ext_a), .ext_b_o(ext_b), .angle_o(angle));

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
      comparisons++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic par_write(input logic [7:0] num, input logic [31:0] data);
      @(negedge clk_i);
      par_wr    = 1'b1;
      par_num   = num;
      par_wdata = data;
      @(negedge clk_i);
      par_wr = 1'b0;
   endtask

   // Answer stands one cycle, so it is taken at the negedge inside that cycle
   task automatic par_read(input logic [7:0] num, output logic [31:0] data);
      @(negedge clk_i);
      par_rd  = 1'b1;
      par_num = num;
      @(negedge clk_i);
      check("read valid", 32'h1, {31'h0, par_rvalid});
      data   = par_rdata;
      par_rd = 1'b0;
   endtask

   task automatic rd_check(input string what, input logic [7:0] num, input logic [31:0] exp);
      logic [31:0] v;
      par_read(num, v);
      check(what, exp, v);
   endtask

   task automatic test_reset_values();
      rd_check("delay reset", axis_pkg::IDX_STANDBY_DELAY, 32'h0000_00c8);
      rd_check("limit reset", axis_pkg::IDX_ENC_DEV_LIMIT, 32'h0000_0000);
      rd_check("ext limit reset", axis_pkg::IDX_EXT_DEV_LIMIT, 32'h0000_0000);
      rd_check("count reset", axis_pkg::IDX_ENC_COUNT, 32'h0000_0000);
      rd_check("unmapped", 8'hd3, 32'h0000_0000);
      par_write(axis_pkg::IDX_ENC_DIVIDER, 32'h1234_5678);
      par_write(axis_pkg::IDX_EXT_DIVIDER, 32'h0000_abcd);
      rd_check("divider", axis_pkg::IDX_ENC_DIVIDER, 32'h1234_5678);
      rd_check("ext divider", axis_pkg::IDX_EXT_DIVIDER, 32'h0000_abcd);
      check("divider out", 32'h1234_5678, enc_div);
      check("ext divider out", 32'h0000_abcd, ext_div);
      $display("test reset_values done");
   endtask

   task automatic test_status();
      for (int i = 0; i < 7; i++)
      begin
         i_driver_model.set_flags(7'h01 << i);
         wait_cyc(5);
         rd_check("status bit", axis_pkg::IDX_FAULT_STATUS, 32'h80 | (32'h1 << i));
      end
      i_driver_model.set_flags(7'h00);
      par_write(axis_pkg::IDX_FAULT_STATUS, 32'h0000_00ff);
      wait_cyc(5);
      rd_check("status read only", axis_pkg::IDX_FAULT_STATUS, 32'h0000_0080);
      $display("test status done");
   endtask

   task automatic test_standstill();
      par_write(axis_pkg::IDX_STANDBY_DELAY, 32'h0000_0002);
      wait_cyc(30);
      check("standby idle", 32'h1, {31'h0, standby});
      i_driver_model.step_pulse();
      wait_cyc(6);
      check("standby after step", 32'h0, {31'h0, standby});
      rd_check("still cleared", axis_pkg::IDX_FAULT_STATUS, 32'h0000_0000);
      check("standby held", 32'h0, {31'h0, standby});
      wait_cyc(4);
      check("standby reached", 32'h1, {31'h0, standby});
      wait_cyc(21);
      rd_check("still set", axis_pkg::IDX_FAULT_STATUS, 32'h0000_0080);
      check("standby again", 32'h1, {31'h0, standby});
      $display("test standstill done");
   endtask

   // Load near the signed limit, then count across it both ways
   task automatic test_counters();
      logic [7:0] num;
      for (int e = 0; e < 2; e++)
      begin
         num = e ? axis_pkg::IDX_EXT_COUNT : axis_pkg::IDX_ENC_COUNT;
         par_write(num, 32'h7fff_ffff);
         i_driver_model.move(e, 1'b1, 1);
         rd_check("count wrap", num, 32'h8000_0000);
         i_driver_model.move(e, 1'b0, 2);
         rd_check("count down", num, 32'h7fff_fffe);
         par_write(num, 32'h0000_0000);
      end
      $display("test counters done");
   endtask

   task automatic dev_case(input logic [31:0] pos, input logic exp);
      @(negedge clk_i);
      act_pos = pos;
      wait_cyc(3);
      check("motor stop", {31'h0, exp}, {31'h0, motor_stop});
   endtask

   task automatic test_deviation();
      logic [7:0] lim;
      par_write(axis_pkg::IDX_ENC_DEV_LIMIT, 32'hffff_ffff);
      rd_check("limit bit 31", axis_pkg::IDX_ENC_DEV_LIMIT, 32'h7fff_ffff);
      par_write(axis_pkg::IDX_ENC_DEV_LIMIT, 32'h0000_0000);
      for (int e = 0; e < 2; e++)
      begin
         lim = e ? axis_pkg::IDX_EXT_DEV_LIMIT : axis_pkg::IDX_ENC_DEV_LIMIT;
         dev_case(32'h0000_03e8, 1'b0);
         par_write(lim, 32'h0000_0005);
         dev_case(32'h0000_0005, 1'b0);
         dev_case(32'h0000_0006, 1'b1);
         dev_case(32'hffff_fffa, 1'b1);
         dev_case(32'hffff_fffb, 1'b0);
         par_write(lim, 32'h0000_0000);
         dev_case(32'hffff_fffa, 1'b0);
      end
      $display("test deviation done");
   endtask

   task automatic test_resolver();
      i_driver_model.set_angle(10'h3ff);
      wait_cyc(4);
      rd_check("angle max", axis_pkg::IDX_RESOLVER_ANGLE, 32'h0000_03ff);
      i_driver_model.set_angle(10'h155);
      wait_cyc(4);
      rd_check("angle mid", axis_pkg::IDX_RESOLVER_ANGLE, 32'h0000_0155);
      par_write(axis_pkg::IDX_RESOLVER_ANGLE, 32'h0000_0000);
      rd_check("angle read only", axis_pkg::IDX_RESOLVER_ANGLE, 32'h0000_0155);
      $display("test resolver done");
   endtask

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Whole run needs under 3000 cycles; the ceiling leaves ample margin
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_mismatch++;
         $display("timeout after %0d cycles", cycles);
         give_verdict();
      end
   end

   initial
   begin
      par_wr    = 1'b0;
      par_rd    = 1'b0;
      par_num   = 8'h00;
      par_wdata = 32'h0000_0000;
      act_pos   = 32'h0000_0000;
      repeat (8) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      wait_cyc(2);
      test_reset_values();
      test_status();
      test_standstill();
      test_counters();
      test_deviation();
      test_resolver();
      give_verdict();
   end
endmodule
`default_nettype wire

//--- test/driver_model.sv
// Behavioural model of the driver flags, step line, two encoders and resolver
`timescale 1ns/1ps
`default_nettype none
module driver_model (
   input  wire logic       clk_i,
   output logic [6:0]      flags_o,
   output logic            step_o,
   output logic            enc_a_o,
   output logic            enc_b_o,
   output logic            ext_a_o,
   output logic            ext_b_o,
   output logic [9:0]      angle_o
);
   logic [1:0] ph_int;
   logic [1:0] ph_ext;

   initial
   begin
      flags_o = 7'h00;
      step_o  = 1'b0;
      angle_o = 10'h000;
      ph_int  = 2'h0;
      ph_ext  = 2'h0;
   end

   // Gray phase sequence, A leads B when counting up
   assign enc_a_o = ph_int[0] ^ ph_int[1];
   assign enc_b_o = ph_int[1];
   assign ext_a_o = ph_ext[0] ^ ph_ext[1];
   assign ext_b_o = ph_ext[1];

   // Driver holds flags as levels until told otherwise
   task automatic set_flags(input logic [6:0] f);
      @(negedge clk_i);
      flags_o = f;
   endtask

   // Step held two cycles so the synchroniser cannot miss it
   task automatic step_pulse();
      @(negedge clk_i);
      step_o = 1'b1;
      repeat (2) @(negedge clk_i);
      step_o = 1'b0;
   endtask

   // One phase change per call step, slow enough for the 2FF path
   task automatic move(input bit ext, input bit up, input int n);
      repeat (n)
      begin
         @(negedge clk_i);
         if (ext) ph_ext = up ? ph_ext + 2'h1 : ph_ext - 2'h1;
         else ph_int = up ? ph_int + 2'h1 : ph_int - 2'h1;
         repeat (3) @(negedge clk_i);
      end
   endtask

   // Resolver changes only between reads, so the sampler sees a settled word
   task automatic set_angle(input logic [9:0] a);
      @(negedge clk_i);
      angle_o = a;
   endtask
endmodule
`default_nettype wire
